// >>> include/pfh_pkg.sv
// constants, timing counts and command codes of the parallel flash host
package pfh_pkg;
    localparam int AW = 18;
    localparam int DW = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_ACC_NS = 70;
    localparam int T_WP_NS = 50;
    localparam int T_AH_NS = 50;
    localparam int T_WPH_NS = 40;
    localparam int STROBE_HIGH_PULSE_TIME_NS = 150;
    localparam int PROGRAM_CYCLE_TIME_US = 50;
    localparam int ERASE_CYCLE_TIME_S = 5;
    // least times round up to whole cycles
    localparam int T_RD_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_AH_CYC = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WHOLD_CYC = (T_AH_CYC > T_WPH_CYC) ? T_AH_CYC : T_WPH_CYC;
    localparam int STROBE_HIGH_PULSE_TIME_CYC =
        (STROBE_HIGH_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest times round down
    localparam int PROG_CYC = PROGRAM_CYCLE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int ERASE_CYC = ERASE_CYCLE_TIME_S * CLK_HZ;
    localparam int TO_W = 27;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] WP_LAST = CNT_W'(T_WP_CYC - 1);
    localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(T_RD_CYC - 1);
    localparam logic [CNT_W-1:0] WGAP_LAST = CNT_W'(T_WHOLD_CYC - 1);
    localparam logic [CNT_W-1:0] RGAP_LAST = CNT_W'(STROBE_HIGH_PULSE_TIME_CYC - 1);
    localparam logic [AW-1:0] ADDR_UNLOCK1 = 18'h05555;
    localparam logic [AW-1:0] ADDR_UNLOCK2 = 18'h02AAA;
    localparam logic [7:0] CMD_PAD = 8'h00;
    localparam logic [7:0] D_UNLOCK1 = 8'hAA;
    localparam logic [7:0] D_UNLOCK2 = 8'h55;
    localparam logic [7:0] D_ERASE_SETUP = 8'h80;
    localparam logic [7:0] D_PROG_SETUP = 8'hA0;
    localparam logic [7:0] D_CHIP_ERASE = 8'h10;
    localparam logic [7:0] D_SECT_ERASE = 8'h30;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam logic [2:0] LAST_STEP_READ = 3'h0;
    localparam logic [2:0] LAST_STEP_PROG = 3'h3;
    localparam logic [2:0] LAST_STEP_ERASE = 3'h5;
    typedef enum logic [1:0] {
        PFH_CMD_READ = 2'h0,
        PFH_CMD_PROG = 2'h1,
        PFH_CMD_CHIP_ERASE = 2'h2,
        PFH_CMD_SECT_ERASE = 2'h3
    } pfh_cmd_e;
endpackage

// >>> include/pfh_cyc_if.sv
// one bus cycle request and its answer between sequencer and engine
`timescale 1ns/1ps
interface pfh_cyc_if;
    import pfh_pkg::*;
    logic req;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic done;
    modport ctl (output req, output wr, output addr, output wdata,
                 input rdata, input done);
    modport eng (input req, input wr, input addr, input wdata,
                 output rdata, output done);
endinterface

// >>> logic/pfh_bus_cycle.sv
// single read or write strobe cycle on the flash pins
`timescale 1ns/1ps
module pfh_bus_cycle (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    pfh_cyc_if.eng cyc,
    output logic ce_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic [pfh_pkg::AW-1:0] addr_out,
    output logic [pfh_pkg::DW-1:0] dq_out,
    output logic dq_oe_n_out,
    input wire logic [pfh_pkg::DW-1:0] dq_in
);
    import pfh_pkg::*;

    typedef enum logic [1:0] {
        PFH_E_IDLE = 2'b00,
        PFH_E_SETUP = 2'b01,
        PFH_E_STROBE = 2'b11,
        PFH_E_HOLD = 2'b10
    } pfh_eng_e;

    pfh_eng_e state;
    logic [CNT_W-1:0] cnt;
    logic wr;
    wire cnt_zero = (cnt == '0);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= PFH_E_IDLE;
            cnt <= '0;
            wr <= 1'b0;
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
            addr_out <= '0;
            dq_out <= '0;
            dq_oe_n_out <= 1'b1;
            cyc.rdata <= '0;
            cyc.done <= 1'b0;
        end else begin
            cyc.done <= 1'b0;
            case (state)
                PFH_E_IDLE: if (cyc.req) begin
                    wr <= cyc.wr;
                    addr_out <= cyc.addr;
                    dq_out <= cyc.wdata;
                    dq_oe_n_out <= !cyc.wr;
                    ce_n_out <= 1'b0;
                    state <= PFH_E_SETUP;
                end
                // oe stays high for the whole write cycle
                PFH_E_SETUP: begin
                    if (wr) begin
                        we_n_out <= 1'b0;
                        cnt <= WP_LAST;
                    end else begin
                        oe_n_out <= 1'b0;
                        cnt <= RD_LAST;
                    end
                    state <= PFH_E_STROBE;
                end
                PFH_E_STROBE: if (cnt_zero) begin
                    we_n_out <= 1'b1;
                    oe_n_out <= 1'b1;
                    ce_n_out <= 1'b1;
                    if (!wr) begin
                        cyc.rdata <= dq_in;
                    end
                    cnt <= wr ? WGAP_LAST : RGAP_LAST;
                    state <= PFH_E_HOLD;
                end else begin
                    cnt <= cnt - 1'b1;
                end
                // address and data held until the gap expires
                PFH_E_HOLD: if (cnt_zero) begin
                    dq_oe_n_out <= 1'b1;
                    cyc.done <= 1'b1;
                    state <= PFH_E_IDLE;
                end else begin
                    cnt <= cnt - 1'b1;
                end
                default: state <= PFH_E_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_read_gap;
        oe_n_out [*3];
    endsequence

    sequence s_write_pulse;
        (!we_n_out && !dq_oe_n_out) ##1 (we_n_out && !dq_oe_n_out);
    endsequence

    a_oe_high_write: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !we_n_out |-> (oe_n_out && !ce_n_out))
        else $error("oe low or chip deselected during write pulse");

    a_write_pulse_shape: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        $fell(we_n_out) |-> s_write_pulse)
        else $error("write pulse width or data hold wrong");

    a_strobe_high_gap: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        $rose(oe_n_out) |-> s_read_gap)
        else $error("read strobe high time too short");

    a_no_contention: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !dq_oe_n_out |-> oe_n_out)
        else $error("host drives data while flash outputs enabled");
endmodule // pfh_bus_cycle

// >>> logic/pfh_host.sv
// host controller: command sequences and completion polling of the flash
//
// Overview of operation
// - output enable stays high while write enable and chip select are low
// - chip erase final write goes to address 5555
// - sector erase final write goes to an address inside the sector
// - final erase data is 10 for chip, 30 for sector erase
// - toggle reads repeat with strobes high at least 150 ns between
// - completion judged by two successive equal toggle bits, or by the timeout
// - every status read during polling uses the same address
`timescale 1ns/1ps
module pfh_host #(
    parameter int ERASE_TO_CYC = pfh_pkg::ERASE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic cmd_valid_in,
    input wire pfh_pkg::pfh_cmd_e cmd_in,
    input wire logic [pfh_pkg::AW-1:0] cmd_addr_in,
    input wire logic [pfh_pkg::DW-1:0] cmd_data_in,
    output logic cmd_ready_out,
    output logic rsp_valid_out,
    output logic [pfh_pkg::DW-1:0] rsp_data_out,
    output logic rsp_timeout_out,
    output logic flash_rst_n_out,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    output logic [pfh_pkg::AW-1:0] flash_addr_out,
    output logic [pfh_pkg::DW-1:0] flash_dq_out,
    output logic flash_dq_oe_n_out,
    input wire logic [pfh_pkg::DW-1:0] flash_dq_in
);
    import pfh_pkg::*;

    typedef enum logic [2:0] {
        PFH_ST_IDLE = 3'b000,
        PFH_ST_SEND = 3'b001,
        PFH_ST_SWAIT = 3'b011,
        PFH_ST_POLL = 3'b010,
        PFH_ST_PWAIT = 3'b110,
        PFH_ST_FIN = 3'b111
    } pfh_state_e;

    pfh_state_e state;
    pfh_state_e next_state;
    pfh_cmd_e cmd;
    logic [AW-1:0] tgt_addr;
    logic [DW-1:0] tgt_data;
    logic [2:0] step;
    logic prev_tog;
    logic prev_valid;
    logic [TO_W-1:0] tocnt;
    logic req;

    pfh_cyc_if cyc ();

    ////////////////////////////////////////////////////////////////////////
    // one word of a command sequence: {write, address, data}
    function automatic logic [AW+DW:0] seq_word(
        input pfh_cmd_e c,
        input logic [2:0] s,
        input logic [AW-1:0] a,
        input logic [DW-1:0] d
    );
        logic [AW+DW:0] w;
        w = {1'b0, a, d};
        if (c != PFH_CMD_READ) begin
            case (s)
                3'h0: w = {1'b1, ADDR_UNLOCK1, CMD_PAD, D_UNLOCK1};
                3'h1: w = {1'b1, ADDR_UNLOCK2, CMD_PAD, D_UNLOCK2};
                3'h2: w = {1'b1, ADDR_UNLOCK1, CMD_PAD,
                           (c == PFH_CMD_PROG) ? D_PROG_SETUP : D_ERASE_SETUP};
                3'h3: w = (c == PFH_CMD_PROG) ? {1'b1, a, d} :
                          {1'b1, ADDR_UNLOCK1, CMD_PAD, D_UNLOCK1};
                3'h4: w = {1'b1, ADDR_UNLOCK2, CMD_PAD, D_UNLOCK2};
                default: w = (c == PFH_CMD_CHIP_ERASE) ?
                    {1'b1, ADDR_UNLOCK1, CMD_PAD, D_CHIP_ERASE} :
                    {1'b1, a, CMD_PAD, D_SECT_ERASE};
            endcase
        end
        return w;
    endfunction

    wire [AW+DW:0] cur_word = seq_word(cmd, step, tgt_addr, tgt_data);
    wire polling = (state == PFH_ST_POLL);
    wire [2:0] last_step = (cmd == PFH_CMD_READ) ? LAST_STEP_READ :
                           (cmd == PFH_CMD_PROG) ? LAST_STEP_PROG :
                           LAST_STEP_ERASE;
    wire [TO_W-1:0] to_limit = (cmd == PFH_CMD_PROG) ? TO_W'(PROG_CYC) :
                               TO_W'(ERASE_TO_CYC);
    wire timed_out = (tocnt >= to_limit);
    wire new_tog = cyc.rdata[TOGGLE_STATUS_BIT];
    // start and end values of the toggle bit vary, so only compare
    wire settled = prev_valid && (new_tog == prev_tog);
    wire op_end = cyc.done && (settled || timed_out);

    assign cyc.req = req;
    assign cyc.wr = polling ? 1'b0 : cur_word[AW+DW];
    // polling keeps the target address fixed
    assign cyc.addr = polling ? tgt_addr : cur_word[AW+DW-1:DW];
    assign cyc.wdata = cur_word[DW-1:0];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        case (state)
            PFH_ST_IDLE: if (cmd_valid_in) begin
                next_state = PFH_ST_SEND;
            end
            PFH_ST_SEND: next_state = PFH_ST_SWAIT;
            PFH_ST_SWAIT: if (cyc.done) begin
                if (step != last_step) begin
                    next_state = PFH_ST_SEND;
                end else if (cmd == PFH_CMD_READ) begin
                    next_state = PFH_ST_FIN;
                end else begin
                    next_state = PFH_ST_POLL;
                end
            end
            PFH_ST_POLL: next_state = PFH_ST_PWAIT;
            PFH_ST_PWAIT: if (op_end) begin
                next_state = PFH_ST_FIN;
            end else if (cyc.done) begin
                next_state = PFH_ST_POLL;
            end
            default: next_state = PFH_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= PFH_ST_IDLE;
            req <= 1'b0;
            cmd_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            flash_rst_n_out <= 1'b0;
        end else begin
            state <= next_state;
            req <= (next_state == PFH_ST_SEND) || (next_state == PFH_ST_POLL);
            cmd_ready_out <= (next_state == PFH_ST_IDLE);
            rsp_valid_out <= (next_state == PFH_ST_FIN);
            flash_rst_n_out <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd <= PFH_CMD_READ;
            tgt_addr <= '0;
            tgt_data <= '0;
            step <= 3'h0;
            prev_tog <= 1'b0;
            prev_valid <= 1'b0;
            tocnt <= '0;
            rsp_data_out <= '0;
            rsp_timeout_out <= 1'b0;
        end else if (state == PFH_ST_IDLE && cmd_valid_in) begin
            cmd <= cmd_in;
            tgt_addr <= cmd_addr_in;
            tgt_data <= cmd_data_in;
            step <= 3'h0;
            prev_valid <= 1'b0;
            tocnt <= '0;
            rsp_timeout_out <= 1'b0;
        end else if (state == PFH_ST_SWAIT && cyc.done) begin
            step <= step + 3'h1;
            rsp_data_out <= cyc.rdata;
        end else if (state == PFH_ST_POLL || state == PFH_ST_PWAIT) begin
            // counts the whole poll loop, saturating at the limit
            tocnt <= timed_out ? tocnt : tocnt + 1'b1;
            if (cyc.done) begin
                prev_tog <= new_tog;
                prev_valid <= 1'b1;
                rsp_data_out <= cyc.rdata;
                rsp_timeout_out <= timed_out && !settled;
            end
        end
    end

    pfh_bus_cycle u_bus_cycle (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .cyc(cyc.eng),
        .ce_n_out(flash_ce_n_out),
        .oe_n_out(flash_oe_n_out),
        .we_n_out(flash_we_n_out),
        .addr_out(flash_addr_out),
        .dq_out(flash_dq_out),
        .dq_oe_n_out(flash_dq_oe_n_out),
        .dq_in(flash_dq_in)
    );

    ////////////////////////////////////////////////////////////////////////
    wire final_erase = req && !polling && (step == LAST_STEP_ERASE);

    a_chip_final_addr: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (final_erase && cmd == PFH_CMD_CHIP_ERASE) |->
            (cyc.wr && cyc.addr == 18'h05555))
        else $error("chip erase final write not at 5555");

    a_sect_final_addr: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (final_erase && cmd == PFH_CMD_SECT_ERASE) |->
            (cyc.wr && cyc.addr == tgt_addr))
        else $error("sector erase final write not at sector address");

    a_erase_code: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        final_erase |-> (cyc.wdata[7:0] ==
            ((cmd == PFH_CMD_CHIP_ERASE) ? 8'h10 : 8'h30)))
        else $error("wrong erase confirm code");

    a_toggle_settle: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (state == PFH_ST_PWAIT && cyc.done && settled) |=>
            (state == PFH_ST_FIN && rsp_valid_out && !rsp_timeout_out))
        else $error("equal toggle reads did not end the operation");

    a_toggle_repoll: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (state == PFH_ST_PWAIT && cyc.done && !settled && !timed_out) |=>
            (state == PFH_ST_POLL) ##1 !rsp_valid_out)
        else $error("differing toggle reads ended the operation");

    a_poll_same_addr: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (req && polling) |-> (!cyc.wr && cyc.addr == tgt_addr &&
            $stable(tgt_addr)))
        else $error("status read address moved during polling");

    a_poll_rate: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (req && polling) |-> ##[5:12] cyc.done)
        else $error("status read did not complete in time");
endmodule // pfh_host

// >>> tb/pfh_flash_model.sv
// behavioural parallel flash device seen from the host controller
`timescale 1ns/1ps
module pfh_flash_model
    import pfh_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DW-1:0] host_dq_in,
    input wire logic host_oe_n_in,
    input wire logic [31:0] busy_ns_in,
    output logic [DW-1:0] dq_out
);
    logic [DW-1:0] mem [logic [AW-1:0]];
    logic [DW-1:0] pdata, rd_val, last;
    logic [7:0] cmd_byte;
    logic [2:0] step = 3'h0;
    logic is_erase = 1'b0;
    logic tgl = 1'b0;
    logic wr_act, rd_act;
    realtime busy_end = 0.0;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [DW-1:0] rd(input logic [AW-1:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    assign wr_act = rst_n_in && !ce_n_in && !we_n_in && oe_n_in;
    assign rd_act = rst_n_in && !ce_n_in && !oe_n_in && we_n_in;
    // released dq never keeps its last level, so a late sample shows up
    always_comb begin
        if (!host_oe_n_in) dq_out = host_dq_in;
        else if (rd_act) dq_out = rd_val;
        else dq_out = ~last;
    end
    always @(posedge sys_clk_in) last <= dq_out;
    always @(negedge rst_n_in) step = 3'h0;
    ////////////////////////////////////////////////////////////////////////
    // status is frozen at read start; toggles once per read strobe
    always @(posedge rd_act) begin
        rd_val = rd(addr_in);
        if ($realtime < busy_end) begin
            tgl = ~tgl;
            rd_val[6] = tgl;
            rd_val[7] = is_erase ? 1'b0 : ~pdata[7];
        end
    end
    // command latched when the write strobe ends
    always @(negedge wr_act) begin
        if (rst_n_in && $realtime >= busy_end) begin
            cmd_byte = host_dq_in[7:0];
            if (step == 3'h3) begin
                pdata = host_dq_in;
                mem[addr_in] = rd(addr_in) & host_dq_in;
                is_erase = 1'b0;
                busy_end = $realtime + busy_ns_in;
                step = 3'h0;
            end else if (step == 3'h6) begin
                is_erase = 1'b1;
                step = 3'h0;
                if (cmd_byte == D_CHIP_ERASE && addr_in == ADDR_UNLOCK1) begin
                    mem.delete();
                    busy_end = $realtime + busy_ns_in;
                end else if (cmd_byte == D_SECT_ERASE) begin
                    foreach (mem[k]) begin
                        if (k[AW-1:12] == addr_in[AW-1:12]) begin
                            mem[k] = 16'hFFFF;
                        end
                    end
                    busy_end = $realtime + busy_ns_in;
                end
            end else if (step == 3'h0 || step == 3'h4) begin
                step = (addr_in == ADDR_UNLOCK1 && cmd_byte == D_UNLOCK1)
                    ? step + 3'h1 : 3'h0;
            end else if (step == 3'h1 || step == 3'h5) begin
                step = (addr_in == ADDR_UNLOCK2 && cmd_byte == D_UNLOCK2)
                    ? step + 3'h1 : 3'h0;
            end else begin
                step = (cmd_byte == D_PROG_SETUP) ? 3'h3
                    : (cmd_byte == D_ERASE_SETUP) ? 3'h4 : 3'h0;
            end
        end
    end
endmodule // pfh_flash_model

// >>> tb/tb_pfh_host.sv
// testbench of the parallel flash host against a behavioural flash
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module tb_pfh_host;
    import pfh_pkg::*;
    localparam int ETO = 200;
    localparam int LIMIT = 20000;
    logic sys_clk_in, nrst_in, cmd_valid_in;
    pfh_cmd_e cmd_in;
    logic [AW-1:0] cmd_addr_in, flash_addr_out;
    logic [DW-1:0] cmd_data_in, rsp_data_out, flash_dq_out, dq_wire;
    logic cmd_ready_out, rsp_valid_out, rsp_timeout_out, flash_rst_n_out;
    logic flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_dq_oe_n_out;
    logic [31:0] busy_ns;
    logic prev_we, prev_oe;
    int n_errors, n_checks, cyc, gap;
    logic [AW-1:0] wr_a[$];
    logic [DW-1:0] wr_d[$];
    logic [AW-1:0] rd_a[$];
    logic [AW-1:0] pa[5] = '{ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_UNLOCK1,
        ADDR_UNLOCK1, ADDR_UNLOCK2};
    logic [7:0] pd[5] = '{D_UNLOCK1, D_UNLOCK2, D_ERASE_SETUP, D_UNLOCK1,
        D_UNLOCK2};
    ////////////////////////////////////////////////////////////////////////
    pfh_host #(.ERASE_TO_CYC(ETO)) dut (.sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
        .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .rsp_timeout_out(rsp_timeout_out),
        .flash_rst_n_out(flash_rst_n_out), .flash_ce_n_out(flash_ce_n_out),
        .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out),
        .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
        .flash_dq_oe_n_out(flash_dq_oe_n_out), .flash_dq_in(dq_wire));
    pfh_flash_model fm (.sys_clk_in(sys_clk_in),
        .rst_n_in(flash_rst_n_out), .ce_n_in(flash_ce_n_out),
        .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
        .addr_in(flash_addr_out), .host_dq_in(flash_dq_out),
        .host_oe_n_in(flash_dq_oe_n_out), .busy_ns_in(busy_ns),
        .dq_out(dq_wire));
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // bus watcher: strobe relations, write log, poll addresses and gaps
    always @(posedge sys_clk_in) begin
        cyc++;
        if (nrst_in) begin
            if (!flash_we_n_out) `CHK(flash_oe_n_out, 1'b1)
            if (!flash_oe_n_out) `CHK(flash_dq_oe_n_out, 1'b1)
            if (prev_we === 1'b0 && flash_we_n_out === 1'b1) begin
                wr_a.push_back(flash_addr_out);
                wr_d.push_back(flash_dq_out);
            end
            if (prev_oe === 1'b1 && flash_oe_n_out === 1'b0) begin
                rd_a.push_back(flash_addr_out);
                `CHK(gap >= 3, 1'b1)
            end
        end
        gap = flash_oe_n_out ? gap + 1 : 0;
        prev_we = flash_we_n_out;
        prev_oe = flash_oe_n_out;
        // a hang anywhere ends here as a mismatch
        if (cyc == LIMIT) begin
            n_errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic do_cmd(input pfh_cmd_e c, input logic [AW-1:0] a,
        input logic [DW-1:0] d);
        wr_a.delete();
        wr_d.delete();
        rd_a.delete();
        cmd_valid_in <= 1'b1;
        cmd_in <= c;
        cmd_addr_in <= a;
        cmd_data_in <= d;
        @(posedge sys_clk_in);
        while (cmd_ready_out !== 1'b1) @(posedge sys_clk_in);
        cmd_valid_in <= 1'b0;
        @(posedge sys_clk_in);
        while (rsp_valid_out !== 1'b1) @(posedge sys_clk_in);
    endtask
    task automatic chk_seq(input int n, input logic [7:0] setup,
        input logic [AW-1:0] la, input logic [DW-1:0] ld);
        `CHK(wr_a.size(), n)
        for (int i = 0; i < n - 1; i++) begin
            `CHK(wr_a[i], pa[i])
            `CHK(wr_d[i], {8'h00, (i == 2) ? setup : pd[i]})
        end
        `CHK(wr_a[n-1], la)
        `CHK(wr_d[n-1], ld)
    endtask
    task automatic chk_read(input logic [AW-1:0] a, input logic [DW-1:0] e);
        do_cmd(PFH_CMD_READ, a, 16'h0000);
        `CHK(rsp_data_out, e)
    endtask
    // program, poll to completion, read back
    task automatic t_program(input logic [AW-1:0] a, input logic [DW-1:0] d);
        busy_ns <= 32'd3000;
        do_cmd(PFH_CMD_PROG, a, d);
        chk_seq(4, D_PROG_SETUP, a, d);
        `CHK(rsp_timeout_out, 1'b0)
        `CHK(rsp_data_out, d)
        `CHK(rd_a.size() > 2, 1'b1)
        foreach (rd_a[i]) `CHK(rd_a[i], a)
        chk_read(a, d);
    endtask
    // sector erase clears only the addressed sector, chip erase all
    task automatic t_erase();
        t_program(18'h03010, 16'h1234);
        t_program(18'h3F020, 16'h5678);
        do_cmd(PFH_CMD_SECT_ERASE, 18'h03ABC, 16'h0000);
        chk_seq(6, D_ERASE_SETUP, 18'h03ABC, 16'h0030);
        `CHK(rsp_timeout_out, 1'b0)
        chk_read(18'h03010, 16'hFFFF);
        chk_read(18'h3F020, 16'h5678);
        do_cmd(PFH_CMD_CHIP_ERASE, 18'h3F020, 16'h0000);
        chk_seq(6, D_ERASE_SETUP, ADDR_UNLOCK1, 16'h0010);
        foreach (rd_a[i]) `CHK(rd_a[i], 18'h3F020)
        chk_read(18'h3F020, 16'hFFFF);
    endtask
    // too slow a flash: a program timeout, a command sent while still busy, then an erase timeout
    task automatic t_slow();
        busy_ns <= 32'd60000;
        do_cmd(PFH_CMD_PROG, 18'h00200, 16'h0F0F);
        `CHK(rsp_timeout_out, 1'b1)
        `CHK(rsp_data_out[7], 1'b1)
        do_cmd(PFH_CMD_PROG, 18'h00300, 16'h0000);
        chk_read(18'h00300, 16'hFFFF);
        busy_ns <= 32'd20000;
        do_cmd(PFH_CMD_CHIP_ERASE, 18'h00200, 16'h0000);
        `CHK(rsp_timeout_out, 1'b1)
        `CHK(rsp_data_out[7], 1'b0)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_in = 1'b0;
        cmd_valid_in = 1'b0;
        cmd_in = PFH_CMD_READ;
        cmd_addr_in = '0;
        cmd_data_in = '0;
        busy_ns = 32'd3000;
        gap = 100;
        repeat (20) @(posedge sys_clk_in);
        `CHK(flash_rst_n_out, 1'b0)
        `CHK({flash_ce_n_out, flash_oe_n_out, flash_we_n_out}, 3'h7)
        `CHK(flash_dq_oe_n_out, 1'b1)
        nrst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        `CHK(cmd_ready_out, 1'b1)
        `CHK(flash_rst_n_out, 1'b1)
        chk_read(18'h00055, 16'hFFFF);
        t_program(18'h00123, 16'h5A3C);
        t_erase();
        t_slow();
        finish_test();
    end
endmodule // tb_pfh_host
